// ---- cecap_top.sv ----
// Design decisions made here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/100ps
module cecap_top (
  input wire logic i_sys_clk, // 50 MHz system clock
  input wire logic i_reset_n, // async reset, active low
  // channel side events
  input wire logic i_outbound_parity_err, // attachment parity tag
  input wire logic i_addr_sent, // device address put on bidir_data_lines
  input wire logic i_addr_answer, // attachment answered the address
  input wire logic i_inbound_parity_err, // bad parity on inbound_data_bus
  input wire logic i_service_out, // channel service request level
  input wire logic i_service_in, // attachment service acknowledge level
  input wire logic i_sysbus_parity_err, // bad system bus parity
  input wire logic i_cs_active, // cycle steal in progress
  input wire logic i_cs_grant, // cycle steal granted, id valid
  input wire logic [2:0] i_cs_id, // encoded cycle steal id
  input wire logic i_cs_no_resp, // no device responded to cycle steal
  input wire logic i_machine_check, // machine check present
  input wire logic i_proc_error, // control_processor error
  input wire logic i_proc_check, // processor check
  input wire logic i_sense_instr, // sense_level_status_instr executing
  input wire logic i_io_instr, // I/O instruction issued
  input wire logic [3:0] i_dev_addr, // device address of that instruction
  input wire logic i_poll_strobe, // level polled by sense instruction
  input wire logic [3:0] i_poll_level, // polled interrupt level
  // control storage events
  input wire logic i_ecc_corrected, // single-bit error corrected
  input wire logic [4:0] i_ecc_log, // log value of corrected error
  input wire logic i_lsr_write_viol, // forbidden local_storage_register write
  input wire logic i_cs_read, // control storage read completes
  input wire logic i_cs_parity_mode, // 1 parity mode, 0 ecc mode
  input wire logic i_cs_uncorr, // uncorrectable ecc error on read
  input wire logic i_cs_parity_err, // parity error on read
  output logic o_blast, // blast pulse clearing the channel
  output logic o_channel_check, // channel check to control_processor
  // AXI4-Lite slave
  input wire logic [3:0] i_awaddr, // write address
  input wire logic i_awvalid, // write address valid
  output logic o_awready, // write address ready
  input wire logic [31:0] i_wdata, // write data
  input wire logic [3:0] i_wstrb, // write strobes
  input wire logic i_wvalid, // write data valid
  output logic o_wready, // write data ready
  output logic [1:0] o_bresp, // write response
  output logic o_bvalid, // write response valid
  input wire logic i_bready, // write response ready
  input wire logic [3:0] i_araddr, // read address
  input wire logic i_arvalid, // read address valid
  output logic o_arready, // read address ready
  output logic [31:0] o_rdata, // read data
  output logic [1:0] o_rresp, // read response
  output logic o_rvalid, // read data valid
  input wire logic i_rready // read data ready
);
  // ****************************************************************
  // state
  // ****************************************************************
  logic [7:0] fault_r;
  logic [3:0] lastop_r;
  logic [7:0] cserr_r;
  cecap_pkg::cecap_addr_st_t addr_st_r;
  logic addr_tmo;
  logic svc_tmo;
  logic aw_held_r;
  logic w_held_r;
  logic [3:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic sw_clear;
  logic chk_evt;

  // tells whether an address is one of the four registers, SLVERR for anything unmapped
  function automatic logic addr_mapped(input logic [3:0] a);
    return (a == cecap_pkg::OFF_FAULT) || (a == cecap_pkg::OFF_LASTOP) ||
           (a == cecap_pkg::OFF_CSERR) || (a == cecap_pkg::OFF_CTRL);
  endfunction

  // ****************************************************************
  // time-outs
  // ****************************************************************
  // address wait: armed by the address, ended by the answer or expiry
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      addr_st_r <= cecap_pkg::CECAP_AD_IDLE;
    end else begin
      unique case (addr_st_r)
        cecap_pkg::CECAP_AD_IDLE: begin
          if (i_addr_sent && !i_addr_answer) addr_st_r <= cecap_pkg::CECAP_AD_WAIT;
        end
        cecap_pkg::CECAP_AD_WAIT: begin
          if (i_addr_answer || addr_tmo) addr_st_r <= cecap_pkg::CECAP_AD_IDLE;
        end
        default: addr_st_r <= cecap_pkg::CECAP_AD_IDLE;
      endcase
    end
  end

  cecap_timer #(.LIMIT(cecap_pkg::ADDR_ANSWER_CYC)) u_addr_tmr (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_run(addr_st_r == cecap_pkg::CECAP_AD_WAIT && !i_addr_answer),
    .o_expired(addr_tmo)
  );

  // acknowledge must drop while the request stands
  cecap_timer #(.LIMIT(cecap_pkg::SERVICE_DROP_CYC)) u_svc_tmr (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_run(i_service_out && i_service_in),
    .o_expired(svc_tmo)
  );

  // ****************************************************************
  // channel fault flags
  // ****************************************************************
  assign chk_evt = i_outbound_parity_err | addr_tmo | i_inbound_parity_err | svc_tmo;

  // detection has no enable at all; set beats a software clear
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      fault_r <= cecap_pkg::FAULT_RESET;
    end else begin
      if (sw_clear) begin
        fault_r[4:0] <= 5'h00;
        fault_r[cecap_pkg::FB_SENSE] <= 1'b0;
      end
      if (i_outbound_parity_err) fault_r[cecap_pkg::FB_OUT_PAR] <= 1'b1;
      if (addr_tmo) fault_r[cecap_pkg::FB_BAD_ADDR] <= 1'b1;
      if (i_inbound_parity_err) fault_r[cecap_pkg::FB_IN_PAR] <= 1'b1;
      if (svc_tmo) fault_r[cecap_pkg::FB_SVC_TMO] <= 1'b1;
      if (i_sysbus_parity_err) fault_r[cecap_pkg::FB_SYSBUS] <= 1'b1;
      if (i_sense_instr && (i_proc_check || chk_evt)) fault_r[cecap_pkg::FB_SENSE] <= 1'b1;
      // frozen under machine check, except that a processor error in cycle steal still sets it, so software can tell what was running
      if (i_proc_error && i_cs_active) begin
        fault_r[cecap_pkg::FB_CS_ACT] <= 1'b1;
      end else if (!i_machine_check) begin
        fault_r[cecap_pkg::FB_CS_ACT] <= i_cs_active;
      end
      fault_r[5] <= 1'b0;
    end
  end

  // blast only on the conditions that clear the channel
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_blast <= 1'b0;
    end else begin
      o_blast <= addr_tmo | i_inbound_parity_err | svc_tmo;
    end
  end

  // combined check follows the sticky flags in bits 0 to 4, one cycle after they set
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_channel_check <= 1'b0;
    end else begin
      o_channel_check <= |fault_r[4:0];
    end
  end

  // ****************************************************************
  // last operation record
  // ****************************************************************
  // what is captured depends on the current mode bits 6 and 7
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      lastop_r <= cecap_pkg::LASTOP_RESET;
    end else begin
      unique case ({fault_r[cecap_pkg::FB_CS_ACT], fault_r[cecap_pkg::FB_SENSE]})
        2'b00: if (i_io_instr) lastop_r <= i_dev_addr;
        2'b01: if (i_poll_strobe) lastop_r <= i_poll_level;
        2'b10: begin
          if (i_cs_no_resp) lastop_r <= cecap_pkg::LO_NO_RESP;
          else if (i_cs_grant) lastop_r <= {i_cs_id, 1'b0};
        end
        2'b11: lastop_r <= lastop_r;
      endcase
    end
  end

  // ****************************************************************
  // control storage errors
  // ****************************************************************
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cserr_r <= cecap_pkg::CSERR_RESET;
    end else begin
      if (sw_clear) cserr_r <= cecap_pkg::CSERR_RESET;
      if (i_ecc_corrected) cserr_r[4:0] <= i_ecc_log;
      if (i_lsr_write_viol) cserr_r[cecap_pkg::CE_LSR_WR] <= 1'b1;
      if (i_cs_read && (i_cs_parity_mode ? i_cs_parity_err : i_cs_uncorr)) begin
        cserr_r[cecap_pkg::CE_UNCORR] <= 1'b1;
      end
      cserr_r[7] <= 1'b0;
    end
  end

  // ****************************************************************
  // lite bus slave
  // ****************************************************************
  // address and data are taken in either order and held until the response
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_addr_r <= 4'h0;
      w_data_r <= cecap_pkg::RDATA_ZERO;
      w_strb_r <= 4'h0;
      o_bvalid <= 1'b0;
      o_bresp <= cecap_pkg::RESP_OKAY;
    end else begin
      if (o_awready && i_awvalid) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= i_awaddr;
      end
      if (o_wready && i_wvalid) begin
        w_held_r <= 1'b1;
        w_data_r <= i_wdata;
        w_strb_r <= i_wstrb;
      end
      if (aw_held_r && w_held_r && !o_bvalid) begin
        o_bvalid <= 1'b1;
        o_bresp <= addr_mapped(aw_addr_r) ? cecap_pkg::RESP_OKAY : cecap_pkg::RESP_SLVERR;
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  // ready drops while a word is held so no second write slips in
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_awready <= 1'b0;
      o_wready <= 1'b0;
    end else begin
      o_awready <= !aw_held_r && !(o_awready && i_awvalid) && !o_bvalid;
      o_wready <= !w_held_r && !(o_wready && i_wvalid) && !o_bvalid;
    end
  end

  // control write is a clear strobe; the three status registers are read-only
  assign sw_clear = aw_held_r && w_held_r && !o_bvalid && (aw_addr_r == cecap_pkg::OFF_CTRL) &&
                    w_strb_r[0] && w_data_r[cecap_pkg::CTRL_CLEAR];

  // read answers one cycle after the address is taken
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata <= cecap_pkg::RDATA_ZERO;
      o_rresp <= cecap_pkg::RESP_OKAY;
    end else begin
      o_arready <= !o_rvalid && !(o_arready && i_arvalid);
      if (o_arready && i_arvalid) begin
        o_rvalid <= 1'b1;
        o_rresp <= addr_mapped(i_araddr) ? cecap_pkg::RESP_OKAY : cecap_pkg::RESP_SLVERR;
        unique case (i_araddr)
          cecap_pkg::OFF_FAULT: o_rdata <= {24'h00_0000, fault_r};
          cecap_pkg::OFF_LASTOP: o_rdata <= {28'h000_0000, lastop_r};
          cecap_pkg::OFF_CSERR: o_rdata <= {24'h00_0000, cserr_r};
          default: o_rdata <= cecap_pkg::RDATA_ZERO;
        endcase
      end else if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);

  sequence s_blast_check;
    o_blast ##1 o_channel_check;
  endsequence

  a_outbound_par_flag: assert property (i_outbound_parity_err |=> fault_r[0] ##1 o_channel_check)
    else $error("outbound parity not flagged");
  a_addr_timeout: assert property (addr_tmo |=> (fault_r[1] and s_blast_check))
    else $error("address time-out not flagged");
  a_inbound_par_blast: assert property (i_inbound_parity_err |=> (fault_r[2] and s_blast_check))
    else $error("inbound parity not flagged");
  a_service_timeout: assert property (svc_tmo |=> (fault_r[3] and s_blast_check))
    else $error("service time-out not flagged");
  a_sysbus_parity: assert property (i_sysbus_parity_err |=> fault_r[4] && !o_blast ##1 o_channel_check)
    else $error("system bus parity not flagged");
  a_cs_frozen: assert property (i_machine_check && !i_proc_error |=> $stable(fault_r[6]))
    else $error("cycle steal bit moved under machine check");
  a_cs_follows: assert property (!i_machine_check && !i_proc_error |=> fault_r[6] == $past(i_cs_active))
    else $error("cycle steal bit does not follow activity");
  a_sense_flag: assert property (i_sense_instr && i_proc_check |=> fault_r[7])
    else $error("sense instruction check not flagged");
  a_io_addr_rec: assert property (fault_r[7:6] == 2'b00 && i_io_instr |=> lastop_r == $past(i_dev_addr))
    else $error("device address not recorded");
  a_cs_id_rec: assert property (fault_r[7:6] == 2'b01 && i_cs_grant && !i_cs_no_resp
                                |=> lastop_r == {$past(i_cs_id), 1'b0})
    else $error("cycle steal id not recorded");
  a_uncorr_flag: assert property (i_cs_read && !i_cs_parity_mode && i_cs_uncorr |=> cserr_r[6])
    else $error("uncorrectable read not flagged");
  a_proc_cs_flag: assert property (i_proc_error && i_cs_active |=> fault_r[6])
    else $error("processor error in cycle steal not flagged");
endmodule

// ---- cecap_pkg.sv ----
package cecap_pkg;
  // ****************************************************************
  // register map (byte addresses on the lite bus)
  // ****************************************************************
  localparam logic [3:0] OFF_FAULT = 4'h0;
  localparam logic [3:0] OFF_LASTOP = 4'h4;
  localparam logic [3:0] OFF_CSERR = 4'h8;
  localparam logic [3:0] OFF_CTRL = 4'hc;
  localparam logic [7:0] FAULT_RESET = 8'h00;
  localparam logic [3:0] LASTOP_RESET = 4'h0;
  localparam logic [7:0] CSERR_RESET = 8'h00;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int FB_OUT_PAR = 0;
  localparam int FB_BAD_ADDR = 1;
  localparam int FB_IN_PAR = 2;
  localparam int FB_SVC_TMO = 3;
  localparam int FB_SYSBUS = 4;
  localparam int FB_CS_ACT = 6;
  localparam int FB_SENSE = 7;
  localparam int CE_LSR_WR = 5;
  localparam int CE_UNCORR = 6;
  localparam int CTRL_CLEAR = 0;
  localparam logic [3:0] LO_NO_RESP = 4'h1;
  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int ADDR_ANSWER_NS = 10000;
  localparam int SERVICE_DROP_NS = 10000;
  localparam int ADDR_ANSWER_CYC = (ADDR_ANSWER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SERVICE_DROP_CYC = (SERVICE_DROP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 12;
  // address wait state
  typedef enum logic [1:0] {
    CECAP_AD_IDLE = 2'b01,
    CECAP_AD_WAIT = 2'b10
  } cecap_addr_st_t;
endpackage

// ---- cecap_timer.sv ----
`timescale 1ns/100ps
module cecap_timer #(
  parameter int LIMIT = 500
) (
  input wire logic i_sys_clk, // system clock
  input wire logic i_reset_n, // async reset, active low
  input wire logic i_run, // count while high, restart when low
  output logic o_expired // one-cycle pulse when the limit is reached
);
  logic [cecap_pkg::TMR_W-1:0] cnt_r;
  localparam logic [cecap_pkg::TMR_W-1:0] LIM = cecap_pkg::TMR_W'(LIMIT);

  // counter stops at the limit so a stuck wait gives a single pulse
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_r <= '0;
      o_expired <= 1'b0;
    end else begin
      o_expired <= 1'b0;
      if (!i_run) begin
        cnt_r <= '0;
      end else if (cnt_r != LIM) begin
        cnt_r <= cnt_r + 1'b1;
        o_expired <= (cnt_r == LIM - 1'b1);
      end
    end
  end
endmodule

// ---- cecap_attach_model.sv ----
`timescale 1ns/100ps
module cecap_attach_model (
  input wire logic i_sys_clk, // system clock
  input wire logic i_reset_n, // async reset, active low
  input wire logic i_addr_sent, // device address offered
  input wire logic i_service_out, // channel service request
  input wire logic i_slow, // answer never, hold acknowledge
  input wire logic i_par_req, // report bad outbound parity
  output logic o_addr_answer, // answer to the address
  output logic o_service_in, // service acknowledge
  output logic o_par_tag // parity tag line
);
  logic [2:0] ans_r;
  logic [2:0] svc_r;
  // ****************************************************************
  // address answer three cycles late; a slow attachment never answers
  // ****************************************************************
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ans_r <= 3'h0;
    end else begin
      ans_r <= {ans_r[1:0], i_addr_sent & ~i_slow};
    end
  end
  assign o_addr_answer = ans_r[2];
  // count cycles of the request; saturates so a stuck acknowledge stays stuck
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      svc_r <= 3'h0;
    end else if (!i_service_out) begin
      svc_r <= 3'h0;
    end else if (svc_r != 3'h7) begin
      svc_r <= svc_r + 3'h1;
    end
  end
  // acknowledge dropped after four cycles unless told to be slow
  assign o_service_in = i_service_out && (svc_r >= 3'h1) && (i_slow || svc_r < 3'h5);
  assign o_par_tag = i_par_req;
endmodule

// ---- channel_error_capture_bench.sv ----
`timescale 1ns/100ps
module channel_error_capture_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [12:0] ev = 13'h0000;
  logic [6:0] lv = 7'h00;
  logic [4:0] dv = 5'h00;
  logic slow = 1'b0;
  logic answer, svc_in, tag, blast, ch_chk;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int fails = 0;
  int checks_done = 0;
  int nb = 0;
  int blasts = 0;
  int cyc = 0;
  // ****************************************************************
  // clock, design and attachment
  // ****************************************************************
  always #(cecap_pkg::CLK_PERIOD_NS / 2) clk = ~clk;
  cecap_top DUT (.i_sys_clk(clk), .i_reset_n(rst_n), .i_outbound_parity_err(tag), .i_addr_sent(ev[0]),
    .i_addr_answer(answer), .i_inbound_parity_err(ev[1]), .i_service_out(lv[0]), .i_service_in(svc_in),
    .i_sysbus_parity_err(ev[2]), .i_cs_active(lv[1]), .i_cs_grant(ev[3]), .i_cs_id(dv[2:0]),
    .i_cs_no_resp(ev[4]), .i_machine_check(lv[2]), .i_proc_error(ev[5]), .i_proc_check(ev[6]),
    .i_sense_instr(lv[3]), .i_io_instr(ev[7]), .i_dev_addr(dv[3:0]), .i_poll_strobe(ev[8]),
    .i_poll_level(dv[3:0]), .i_ecc_corrected(ev[9]), .i_ecc_log(dv), .i_lsr_write_viol(ev[10]),
    .i_cs_read(ev[11]), .i_cs_parity_mode(lv[4]), .i_cs_uncorr(lv[5]), .i_cs_parity_err(lv[6]),
    .o_blast(blast), .o_channel_check(ch_chk), .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
    .i_wdata(wdata), .i_wstrb(4'hf), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
    .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
    .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready));
  cecap_attach_model att (.i_sys_clk(clk), .i_reset_n(rst_n), .i_addr_sent(ev[0]), .i_service_out(lv[0]),
    .i_slow(slow), .i_par_req(ev[12]), .o_addr_answer(answer), .o_service_in(svc_in), .o_par_tag(tag));
  // ****************************************************************
  // compare, stimulus and bus tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: resp %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] fb(input int b);
    return 32'h0000_0001 << b;
  endfunction
  // one-cycle event with its qualifying data held afterwards
  task automatic pulse(input int n, input logic [4:0] d);
    @(posedge clk);
    ev[n] <= 1'b1;
    dv <= d;
    @(posedge clk);
    ev <= 13'h0000;
  endtask
  task automatic lvl(input int n, input logic v);
    @(posedge clk);
    lv[n] <= v;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // handshakes are judged at the falling edge, where registered outputs are settled
  task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_t, w_t, b_t;
    logic [1:0] rsp;
    b_t = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_t) begin
      @(negedge clk);
      aw_t = awvalid & awready;
      w_t = wvalid & wready;
      b_t = bvalid;
      rsp = bresp;
      @(posedge clk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
      if (b_t) bready <= 1'b0;
    end
    chk_resp(rsp, er);
  endtask
  task automatic axr(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ar_t, r_t;
    logic [1:0] rsp;
    logic [31:0] dat;
    r_t = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_t) begin
      @(negedge clk);
      ar_t = arvalid & arready;
      r_t = rvalid;
      rsp = rresp;
      dat = rdata;
      @(posedge clk);
      if (ar_t) arvalid <= 1'b0;
      if (r_t) rready <= 1'b0;
    end
    chk_resp(rsp, er);
    chk(dat, ed);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    axr(a, e, cecap_pkg::RESP_OKAY);
  endtask
  task automatic clr;
    axw(cecap_pkg::OFF_CTRL, 32'h0000_0001, cecap_pkg::RESP_OKAY);
  endtask
  task automatic ck(input logic e);
    @(negedge clk);
    chk({31'h0, ch_chk}, {31'h0, e});
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // blast pulses are counted; the cycle ceiling cuts a hang short
  always @(posedge clk) begin
    cyc++;
    if (blast === 1'b1) blasts++;
    if (cyc == 20000) begin
      fails++;
      end_sim();
    end
  end
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd(4'(i * 4), 32'h0000_0000);
    end
    axw(4'h6, 32'h0000_00ff, cecap_pkg::RESP_SLVERR);
    axr(4'h6, cecap_pkg::RDATA_ZERO, cecap_pkg::RESP_SLVERR);
    axw(cecap_pkg::OFF_FAULT, 32'h0000_00ff, cecap_pkg::RESP_OKAY);
    rd(cecap_pkg::OFF_FAULT, 32'h0000_0000);
    pulse(7, 5'h0c);
    rd(cecap_pkg::OFF_LASTOP, 32'h0000_000c);
    pulse(12, 5'h00);
    rd(cecap_pkg::OFF_FAULT, fb(cecap_pkg::FB_OUT_PAR));
    ck(1'b1);
    clr();
    rd(cecap_pkg::OFF_FAULT, 32'h0000_0000);
    ck(1'b0);
    // prompt attachment first, then one that neither answers nor drops
    for (int s = 0; s < 2; s++) begin
      @(posedge clk);
      slow <= s[0];
      pulse(0, 5'h00);
      lvl(0, 1'b1);
      wt(520);
      lvl(0, 1'b0);
      nb = nb + 2 * s;
      rd(cecap_pkg::OFF_FAULT, s ? (fb(cecap_pkg::FB_BAD_ADDR) | fb(cecap_pkg::FB_SVC_TMO)) : 0);
      chk(blasts, nb);
      ck(s[0]);
      clr();
    end
    pulse(1, 5'h00);
    pulse(2, 5'h00);
    nb++;
    rd(cecap_pkg::OFF_FAULT, fb(cecap_pkg::FB_IN_PAR) | fb(cecap_pkg::FB_SYSBUS));
    chk(blasts, nb);
    ck(1'b1);
    clr();
    lvl(1, 1'b1);
    rd(cecap_pkg::OFF_FAULT, fb(cecap_pkg::FB_CS_ACT));
    pulse(3, 5'h05);
    rd(cecap_pkg::OFF_LASTOP, 32'h0000_000a);
    pulse(4, 5'h00);
    rd(cecap_pkg::OFF_LASTOP, 32'(cecap_pkg::LO_NO_RESP));
    lvl(2, 1'b1);
    lvl(1, 1'b0);
    rd(cecap_pkg::OFF_FAULT, fb(cecap_pkg::FB_CS_ACT));
    lvl(2, 1'b0);
    rd(cecap_pkg::OFF_FAULT, 32'h0000_0000);
    // bit 6 frozen low by a machine check, then forced by a processor error in cycle steal
    lvl(2, 1'b1);
    lvl(1, 1'b1);
    pulse(5, 5'h00);
    lvl(1, 1'b0);
    rd(cecap_pkg::OFF_FAULT, fb(cecap_pkg::FB_CS_ACT));
    lvl(2, 1'b0);
    lvl(3, 1'b1);
    pulse(6, 5'h00);
    lvl(3, 1'b0);
    rd(cecap_pkg::OFF_FAULT, fb(cecap_pkg::FB_SENSE));
    ck(1'b0);
    pulse(8, 5'h09);
    rd(cecap_pkg::OFF_LASTOP, 32'h0000_0009);
    pulse(7, 5'h03);
    rd(cecap_pkg::OFF_LASTOP, 32'h0000_0009);
    clr();
    pulse(9, 5'h15);
    rd(cecap_pkg::OFF_CSERR, 32'h0000_0015);
    pulse(10, 5'h00);
    rd(cecap_pkg::OFF_CSERR, 32'h0000_0035);
    lvl(5, 1'b1);
    pulse(11, 5'h00);
    rd(cecap_pkg::OFF_CSERR, 32'h0000_0075);
    clr();
    lvl(5, 1'b0);
    lvl(4, 1'b1);
    lvl(6, 1'b1);
    pulse(11, 5'h00);
    rd(cecap_pkg::OFF_CSERR, fb(cecap_pkg::CE_UNCORR));
    end_sim();
  end
endmodule
